// [common/tgt_regs_pkg.sv]
// Constants and carrier types for the target status and tx length bank.
// Assumes an APB master with 32-bit data and byte addressing.
package tgt_regs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_TARGET_STATE = 6'h21;
	localparam logic [5:0] IDX_TX_COUNT_HIGH = 6'h22;
	localparam logic [5:0] IDX_TX_COUNT_LOW = 6'h23;
	localparam logic [5:0] IDX_RATE_TIMER = 6'h24;
	localparam logic [5:0] IDX_CONV_RESULT = 6'h25;
	localparam logic [5:0] IDX_TUNE_A = 6'h26;
	localparam logic [5:0] IDX_TUNE_B = 6'h27;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h30;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h31;
	localparam logic [5:0] IDX_CONTROL = 6'h32;
	localparam logic [1:0] WORD_ALIGN = 2'h0;
	// Reset values
	localparam logic [7:0] TUNE_RESET = 8'h80;
	localparam logic [12:0] COUNT_RESET = 13'h0000;
	localparam logic [2:0] EXTRA_RESET = 3'h0;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	// Target state codes
	localparam logic [3:0] ST_POWER_OFF = 4'h0;
	localparam logic [3:0] ST_IDLE = 4'h1;
	localparam logic [3:0] ST_READY_ONE = 4'h2;
	localparam logic [3:0] ST_READY_TWO = 4'h3;
	localparam logic [3:0] ST_ACTIVE = 4'h5;
	localparam logic [3:0] ST_HALT = 4'h9;
	localparam logic [3:0] ST_READY_ONE_STAR = 4'ha;
	localparam logic [3:0] ST_READY_TWO_STAR = 4'hb;
	localparam logic [3:0] ST_ACTIVE_STAR = 4'hd;
	// Interrupt status bit positions
	localparam int IRQ_PARITY = 0;
	localparam int IRQ_ACTIVE = 1;
	localparam int IRQ_CONV = 2;
	localparam int IRQ_W = 3;
	// Control bit: anticollision enable
	localparam int CTL_ANTICOLL = 0;

	typedef struct packed {
		logic [3:0] target_state;
		logic [1:0] detected_rate;
		logic second_field_wait_timer_running;
		logic gp_timer_running;
		logic no_response_timer_running;
		logic mask_rx_timer_running;
		logic [7:0] conv_result;
		logic conv_done;
		logic reqa_wupa_cmd;
		logic type_a_framing;
	} core_status_t;

	typedef struct packed {
		logic [12:0] full_bytes;
		logic [2:0] extra_bits;
		logic parity_off;
	} tx_len_t;

	typedef enum logic [1:0] {
		APB_IDLE,
		APB_WAIT,
		APB_DONE
	} apb_state_t;
endpackage

// [verilog/tgt_status_regs.sv]
// APB register bank: target state view, tx length, rate and timer view,
// converter result, two tuning DAC codes and an interrupt block.
// Assumes core status inputs are synchronous to pclk.
`timescale 1ns/1ns

// What this block does
// - Show the 4-bit type A passive target state code.
// - Full-byte count is 13 bits: upper 8 in high, lower 5 in low[7:3].
// - Low[2:0] counts extra bits after last byte, sent LSB first.
// - Extra bits only with type A framing, sent without parity.
// - Anticollision, idle and extra bits set: REQA/WUPA raises parity irq.
// - Rate register bits 5:4 show detected bit rate; 7:6 reserved.
// - Rate register bits 3:0 show the four timer running flags.
// - Converter register shows last completed conversion, read only.
// - Tuning DAC A code, resets to 0x80.
// - Tuning DAC B code, resets to 0x80.
module tgt_status_regs
	import tgt_regs_pkg::*;
(
	input wire logic pclk, // APB clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // Slave select
	input wire logic penable, // Access phase
	input wire logic pwrite, // 1 write, 0 read
	input wire logic [ADDR_W-1:0] paddr, // Byte address
	input wire logic [DATA_W-1:0] pwdata, // Write data
	output logic [DATA_W-1:0] prdata, // Read data
	output logic pready, // Transfer done
	output logic pslverr, // Unmapped access
	input wire core_status_t core_status, // Live core state
	output tx_len_t tx_len, // Transmit length setup
	output logic [7:0] tune_dac_a, // DAC A code
	output logic [7:0] tune_dac_b, // DAC B code
	output logic irq // Level interrupt
);
	apb_state_t apb_state;
	logic [7:0] count_high;
	logic [7:0] count_low;
	logic [7:0] conv_result;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic anticoll_en;
	logic was_active;
	logic [5:0] index;
	logic aligned;
	logic mapped;
	logic wr_done;
	logic [7:0] rd_byte;
	logic now_active;
	logic [IRQ_W-1:0] events;
	logic [IRQ_W-1:0] w1c;
	logic [IRQ_W-1:0] next_status;

	assign index = paddr[7:2];
	assign aligned = (paddr[1:0] == WORD_ALIGN);

	always_comb begin
		case (index)
			IDX_TARGET_STATE,
			IDX_TX_COUNT_HIGH,
			IDX_TX_COUNT_LOW,
			IDX_RATE_TIMER,
			IDX_CONV_RESULT,
			IDX_TUNE_A,
			IDX_TUNE_B,
			IDX_IRQ_STATUS,
			IDX_IRQ_MASK,
			IDX_CONTROL: begin
				mapped = aligned;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// Writes land only on the edge where pready is seen high
	assign wr_done = psel & penable & pready & pwrite & mapped;

	// Read mux; unlisted indices and reserved bits read zero, unaligned addresses still return the register
	always_comb begin
		rd_byte = BYTE_ZERO;
		case (index)
			IDX_TARGET_STATE: begin
				rd_byte = {4'h0, core_status.target_state};
			end
			IDX_TX_COUNT_HIGH: begin
				rd_byte = count_high;
			end
			IDX_TX_COUNT_LOW: begin
				rd_byte = count_low;
			end
			IDX_RATE_TIMER: begin
				rd_byte = {2'h0, core_status.detected_rate,
					core_status.second_field_wait_timer_running,
					core_status.gp_timer_running,
					core_status.no_response_timer_running,
					core_status.mask_rx_timer_running};
			end
			IDX_CONV_RESULT: begin
				rd_byte = conv_result;
			end
			IDX_TUNE_A: begin
				rd_byte = tune_dac_a;
			end
			IDX_TUNE_B: begin
				rd_byte = tune_dac_b;
			end
			IDX_IRQ_STATUS: begin
				rd_byte = {5'h00, irq_status};
			end
			IDX_IRQ_MASK: begin
				rd_byte = {5'h00, irq_mask};
			end
			IDX_CONTROL: begin
				rd_byte = {7'h00, anticoll_en};
			end
			default: begin
				rd_byte = BYTE_ZERO;
			end
		endcase
	end

	// One wait state so prdata and pready both come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_state <= APB_IDLE;
		end else begin
			case (apb_state)
				APB_IDLE: begin
					if (psel && !penable) begin
						apb_state <= APB_WAIT;
					end
				end
				APB_WAIT: begin
					apb_state <= APB_DONE;
				end
				APB_DONE: begin
					apb_state <= APB_IDLE;
				end
				default: begin
					apb_state <= APB_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= (apb_state == APB_WAIT) && psel && penable;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= WORD_ZERO;
			pslverr <= 1'b0;
		end else if (apb_state == APB_WAIT && psel && penable) begin
			prdata <= pwrite ? WORD_ZERO : {24'h00_0000, rd_byte};
			pslverr <= !mapped;
		end else begin
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_high <= COUNT_RESET[12:5];
			count_low <= {COUNT_RESET[4:0], EXTRA_RESET};
		end else if (wr_done) begin
			if (index == IDX_TX_COUNT_HIGH) begin
				count_high <= pwdata[7:0];
			end
			if (index == IDX_TX_COUNT_LOW) begin
				count_low <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tune_dac_a <= TUNE_RESET;
			tune_dac_b <= TUNE_RESET;
		end else if (wr_done) begin
			if (index == IDX_TUNE_A) begin
				tune_dac_a <= pwdata[7:0];
			end
			if (index == IDX_TUNE_B) begin
				tune_dac_b <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= IRQ_RESET;
			anticoll_en <= 1'b0;
		end else if (wr_done) begin
			if (index == IDX_IRQ_MASK) begin
				irq_mask <= pwdata[IRQ_W-1:0];
			end
			if (index == IDX_CONTROL) begin
				anticoll_en <= pwdata[CTL_ANTICOLL];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_result <= BYTE_ZERO;
		end else if (core_status.conv_done) begin
			conv_result <= core_status.conv_result;
		end
	end

	// extra bits forwarded only with type A framing; parity dropped for split type A frames
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_len <= '0;
		end else begin
			tx_len.full_bytes <= {count_high, count_low[7:3]};
			tx_len.extra_bits <= core_status.type_a_framing
				? count_low[2:0] : EXTRA_RESET;
			tx_len.parity_off <= core_status.type_a_framing
				&& (count_low[2:0] != EXTRA_RESET);
		end
	end

	// Entering active lets the host know it now owns command handling
	assign now_active = (core_status.target_state == ST_ACTIVE)
		|| (core_status.target_state == ST_ACTIVE_STAR);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			was_active <= 1'b0;
		end else begin
			was_active <= now_active;
		end
	end

	always_comb begin
		events = '0;
		events[IRQ_PARITY] = anticoll_en
			&& (core_status.target_state == ST_IDLE)
			&& (count_low[2:0] != EXTRA_RESET)
			&& core_status.reqa_wupa_cmd;
		events[IRQ_ACTIVE] = now_active && !was_active;
		events[IRQ_CONV] = core_status.conv_done;
	end

	assign w1c = (wr_done && index == IDX_IRQ_STATUS)
		? pwdata[IRQ_W-1:0] : IRQ_RESET;

	// A new event in the clearing cycle wins over the clear
	assign next_status = (irq_status & ~w1c) | events;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= IRQ_RESET;
		end else begin
			irq_status <= next_status;
		end
	end

	// Registered so the pin is glitch free; lags status by one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end
endmodule

// [tb/tgt_status_regs_asserts.sv]
// Checker bound to the target status bank ports.
// Assumes core_status is held steady while a read is in flight.
`timescale 1ns/1ns
module tgt_regs_chk
	import tgt_regs_pkg::*;
(
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic psel, // select
	input wire logic penable, // access
	input wire logic pwrite, // write
	input wire logic [ADDR_W-1:0] paddr, // address
	input wire logic [DATA_W-1:0] pwdata, // wdata
	input wire logic [DATA_W-1:0] prdata, // rdata
	input wire logic pready, // done
	input wire logic pslverr, // error
	input wire core_status_t core_status, // core
	input wire tx_len_t tx_len, // length
	input wire logic [7:0] tune_dac_a // DAC A
);
	logic [7:0] last_conv;
	wire rd = pready && !pwrite;
	wire wr = psel && penable && pready && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			last_conv <= 8'h00;
		else if (core_status.conv_done)
			last_conv <= core_status.conv_result;
	end
	AST_STATE_VIEW: assert property (rd && paddr == 8'h84 |->
		prdata[7:0] == {4'h0, core_status.target_state})
		else $error("state view");
	AST_COUNT_HIGH: assert property (wr && paddr == 8'h88 |->
		##2 tx_len.full_bytes[12:5] == $past(pwdata[7:0], 2))
		else $error("count high");
	AST_EXTRA_BITS: assert property (wr && paddr == 8'h8c &&
		core_status.type_a_framing |->
		##2 tx_len.extra_bits == $past(pwdata[2:0], 2) &&
		tx_len.full_bytes[4:0] == $past(pwdata[7:3], 2))
		else $error("count low");
	AST_TYPE_A_ONLY: assert property (
		!$past(core_status.type_a_framing) |-> tx_len.extra_bits == 3'h0)
		else $error("extra bits gate");
	AST_RATE_VIEW: assert property (rd && paddr == 8'h90 |->
		prdata[7:0] == {2'h0, core_status[16:11]})
		else $error("rate view");
	AST_CONV_VIEW: assert property (rd && paddr == 8'h94 |->
		prdata[7:0] == last_conv)
		else $error("conv view");
	AST_DAC_A: assert property (wr && paddr == 8'h98 |->
		##1 tune_dac_a == $past(pwdata[7:0]))
		else $error("DAC A code");
	AST_RO_QUIET: assert property (pready && paddr inside
		{8'h84, 8'h90, 8'h94} |-> !pslverr)
		else $error("read only error");
endmodule
bind tgt_status_regs tgt_regs_chk chk (.*);

// [tb/host_apb.sv]
// Host model: APB master, one transfer at a time.
// Assumes the slave ends each transfer with pready.
`timescale 1ns/1ns
module host_apb (
	input wire logic pclk, // clock
	output logic psel, // select
	output logic penable, // access
	output logic pwrite, // write
	output logic [7:0] paddr, // address
	output logic [31:0] pwdata, // wdata
	input wire logic [31:0] prdata, // rdata
	input wire logic pready, // done
	input wire logic pslverr // error
);
	logic err;
	// Transfers that never saw pready; the bench counts them as mismatches
	int stalls = 0;
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			stalls++;
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle lines show the inverse so stale values never pass
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// [tb/test_tgt_status_regs.sv]
// Bench for the target status and tx length bank.
// Assumes host_apb drives the bus; core status is driven here.
`timescale 1ns/1ns
module test_tgt_status_regs
	import tgt_regs_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr, tune_dac_a, tune_dac_b;
	logic [31:0] pwdata, prdata, r;
	core_status_t core_status = '0;
	tx_len_t tx_len;
	int errors = 0;
	int comparisons = 0;
	always #4 pclk = ~pclk;
	host_apb host (.*);
	tgt_status_regs dut (.*);
	task chk(input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("FAIL t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		host.xfer(1'b0, a, 32'h0000_0000, r);
		chk(r, e);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, r);
	endtask
	task t_reset;
		chk(32'(tune_dac_a), 32'h0000_0080);
		rd(8'h88, 32'h0000_0000);
		rd(8'h8c, 32'h0000_0000);
		rd(8'h9c, 32'h0000_0080);
		wr(8'h9c, 32'h0000_00c3);
		@(posedge pclk);
		chk(32'(tune_dac_b), 32'h0000_00c3);
		wr(8'h98, 32'h0000_003c);
	endtask
	task t_state;
		logic [3:0] codes [9];
		codes = '{ST_POWER_OFF, ST_IDLE, ST_READY_ONE, ST_READY_TWO,
			ST_ACTIVE, ST_HALT, ST_READY_ONE_STAR, ST_READY_TWO_STAR,
			ST_ACTIVE_STAR};
		foreach (codes[i]) begin
			core_status.target_state <= codes[i];
			rd(8'h84, {28'h000_0000, codes[i]});
		end
		// Host learns of takeover through the active-entry status bit
		rd(8'hc0, 32'h0000_0002);
	endtask
	task t_len;
		core_status.type_a_framing <= 1'b1;
		wr(8'h88, 32'h0000_00ff);
		wr(8'h8c, 32'h0000_00fd);
		repeat (2) @(posedge pclk);
		chk(32'(tx_len.full_bytes), 32'h0000_1fff);
		chk(32'(tx_len.extra_bits), 32'h0000_0005);
		chk(32'(tx_len.parity_off), 32'h0000_0001);
		rd(8'h8c, 32'h0000_00fd);
		core_status.type_a_framing <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(32'(tx_len.extra_bits), 32'h0000_0000);
		chk(32'(tx_len.parity_off), 32'h0000_0000);
		// host never asks for short frames outside type A framing
		core_status.type_a_framing <= 1'b1;
	endtask
	task t_views;
		core_status[16:11] <= 6'h2a;
		rd(8'h90, 32'h0000_002a);
		wr(8'h90, 32'h0000_00ff);
		rd(8'h90, 32'h0000_002a);
		core_status.conv_result <= 8'h5a;
		core_status.conv_done <= 1'b1;
		@(posedge pclk);
		core_status.conv_result <= 8'h00;
		core_status.conv_done <= 1'b0;
		rd(8'h94, 32'h0000_005a);
		rd(8'hf0, 32'h0000_0000);
		chk(32'(host.err), 32'h0000_0001);
	endtask
	task t_irq;
		core_status.target_state <= ST_IDLE;
		wr(8'hc0, 32'h0000_0007);
		wr(8'hc8, 32'h0000_0001);
		core_status.reqa_wupa_cmd <= 1'b1;
		@(posedge pclk);
		core_status.reqa_wupa_cmd <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0000_0000);
		rd(8'hc0, 32'h0000_0001);
		wr(8'hc4, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0000_0001);
		wr(8'hc0, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0000_0000);
	endtask
	task results;
		errors += host.stalls;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_state;
		t_len;
		t_views;
		t_irq;
		results;
	end
	// Whole run is well under 1000 cycles
	initial begin
		#20000;
		errors++;
		results;
	end
endmodule
